// >>> logic/bpb_defs.vh
// constants for the bidirectional port bank: widths, offsets, fields and reset values
`ifndef BPB_DEFS_VH
`define BPB_DEFS_VH

// bank shape
`define BPB_PORT_BITS 24
`define BPB_GROUP_BITS 4
`define BPB_ADDR_BITS 8

// register byte offsets on the apb slave
`define BPB_OFS_DATA 8'h00
`define BPB_OFS_DIR 8'h04
`define BPB_OFS_PULL 8'h08
`define BPB_OFS_THRESH 8'h0c
`define BPB_OFS_FUNC 8'h10
`define BPB_OFS_SPECIAL 8'h14
`define BPB_OFS_PINS 8'h18

// reset values
`define BPB_RST_DATA 24'h000000
`define BPB_RST_DIR 24'h000000
`define BPB_RST_PULL 24'hffffff
`define BPB_RST_THRESH 24'hffffff
`define BPB_RST_FUNC 5'h00
`define BPB_RST_SPECIAL 6'h00

// peripheral function select fields
`define BPB_FUNC_CONV 0
`define BPB_FUNC_SERIAL 1
`define BPB_FUNC_MASTER 2
`define BPB_FUNC_WATCH 3
`define BPB_FUNC_EVENT 4
`define BPB_FUNC_BITS 5

// special output enable fields
`define BPB_SPC_BUZZ 0
`define BPB_SPC_TIMER_CLOCK_OUT_A 1
`define BPB_SPC_DIVIDED_CLOCK_OUT 2
`define BPB_SPC_TIMER_CLOCK_OUT_B 3
`define BPB_SPC_TIMER_CLOCK_OUT_C 4
`define BPB_SPC_TIMER_CLOCK_OUT_D 5
`define BPB_SPC_BITS 6

// port bit positions, group number times four plus bit
`define BPB_P00 0
`define BPB_P01 1
`define BPB_P02 2
`define BPB_P03 3
`define BPB_P10 4
`define BPB_P11 5
`define BPB_P12 6
`define BPB_P13 7
`define BPB_P20 8
`define BPB_P21 9
`define BPB_P22 10
`define BPB_P23 11
`define BPB_P31 13
`define BPB_P32 14
`define BPB_P33 15
`define BPB_P41 17
`define BPB_P42 18
`define BPB_P43 19

`endif

// >>> logic/bpb_pin_sync.v
// three-stage pin synchroniser with agreement check for the port bank
`timescale 1ns/1ps
`include "bpb_defs.vh"

module bpb_pin_sync
(
	input wire clk_sys_in,
	input wire rst_in,
	input wire [`BPB_PORT_BITS-1:0] pin_raw_in,
	output reg [`BPB_PORT_BITS-1:0] pin_level_out
);

	reg [`BPB_PORT_BITS-1:0] stage_a;
	reg [`BPB_PORT_BITS-1:0] stage_b;
	reg [`BPB_PORT_BITS-1:0] stage_c;
	reg [`BPB_PORT_BITS-1:0] next_level;
	integer i;

	// a bit only moves once the second and third stages agree, so one-cycle glitches never reach software
	always @*
	begin
		next_level = pin_level_out;
		for (i = 0; i < `BPB_PORT_BITS; i = i + 1)
		begin
			if (stage_b[i] == stage_c[i])
			begin
				next_level[i] = stage_c[i];
			end
		end
	end

	// the first stage feeds only the second one
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			stage_a <= {`BPB_PORT_BITS{1'b0}};
			stage_b <= {`BPB_PORT_BITS{1'b0}};
			stage_c <= {`BPB_PORT_BITS{1'b0}};
			pin_level_out <= {`BPB_PORT_BITS{1'b0}};
		end
		else
		begin
			stage_a <= pin_raw_in;
			stage_b <= stage_a;
			stage_c <= stage_b;
			pin_level_out <= next_level;
		end
	end

endmodule // bpb_pin_sync

// >>> logic/bpb_port_bank.v
// 24-bit bidirectional port bank with apb registers and shared peripheral terminals
//
// Overview of operation
// - 24 port bits, per-bit software direction
// - direction 0 gives undriven input
// - direction 1 drives stored data level
// - output-mode read returns stored data
// - reset clears every direction bit
// - reset selects plain port on all terminals
// - enabled pull-down acts only in input
// - hardware owns direction under shared functions
// - threshold select 0 cmos, 1 schmitt
// - reset selects schmitt on every port
// - threshold select inert on output-type functions
// - threshold select live on peripheral inputs except converter p00
// - p10, p11 feed stopwatch run and lap
// - p12, p41-p43 feed event counters
// - shared terminals selectable for peripheral functions
// - per-bit build-time push-pull or open drain
// - build-time pad choices hold under peripherals
// - pull-down bits enable, reset to one
// - special output forces port to output
`timescale 1ns/1ps
`include "bpb_defs.vh"

module bpb_port_bank
#(
	// bit set: that pad has only the high-side driver
	parameter [`BPB_PORT_BITS-1:0] OPEN_DRAIN_MASK = 24'h000000,
	// bit set: that pad has a pull-down resistor fitted
	parameter [`BPB_PORT_BITS-1:0] PULLDOWN_FITTED = 24'hffffff
)
(
	input wire clk_sys_in,
	input wire rst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [`BPB_ADDR_BITS-1:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	output wire pready_out,
	output reg [31:0] prdata_out,
	output reg pslverr_out,
	input wire [`BPB_PORT_BITS-1:0] pin_in,
	output reg [`BPB_PORT_BITS-1:0] pin_out,
	output reg [`BPB_PORT_BITS-1:0] pin_oe_out,
	output reg [`BPB_PORT_BITS-1:0] pulldown_on_out,
	output reg [`BPB_PORT_BITS-1:0] schmitt_on_out,
	input wire buzzer_out_in,
	input wire timer_clock_out_a_in,
	input wire timer_clock_out_b_in,
	input wire timer_clock_out_c_in,
	input wire timer_clock_out_d_in,
	input wire divided_clock_out_in,
	input wire converter_reference_in,
	input wire converter_sensor_in,
	input wire converter_osc_out_in,
	input wire serial_clock_master_in,
	input wire serial_data_out_pin_in,
	input wire serial_ready_out_in,
	output reg converter_osc_in_out,
	output reg serial_clock_slave_out,
	output reg serial_data_in_pin_out,
	output reg watch_run_stop_out,
	output reg watch_lap_out,
	output reg event_count_in_a_out,
	output reg event_count_in_b_out,
	output reg event_count_in_c_out,
	output reg event_count_in_d_out
);

	// software-visible storage
	reg [`BPB_PORT_BITS-1:0] port_data;
	reg [`BPB_PORT_BITS-1:0] port_direction_bit;
	reg [`BPB_PORT_BITS-1:0] pulldown_enable_bit;
	reg [`BPB_PORT_BITS-1:0] input_threshold_select;
	reg [`BPB_FUNC_BITS-1:0] func_select;
	reg [`BPB_SPC_BITS-1:0] special_enable;

	// per-bit view of the terminal function
	reg [`BPB_PORT_BITS-1:0] hw_owned;
	reg [`BPB_PORT_BITS-1:0] hw_drive;
	reg [`BPB_PORT_BITS-1:0] hw_value;
	reg [`BPB_PORT_BITS-1:0] thresh_inert;
	reg [`BPB_PORT_BITS-1:0] want_drive;
	reg [`BPB_PORT_BITS-1:0] want_value;
	reg [`BPB_PORT_BITS-1:0] next_oe;
	reg [`BPB_PORT_BITS-1:0] next_pull;
	reg [`BPB_PORT_BITS-1:0] next_schmitt;
	reg [`BPB_PORT_BITS-1:0] read_port;
	reg [31:0] next_rdata;
	reg next_slverr;

	wire [`BPB_PORT_BITS-1:0] pin_level;
	wire apb_setup;
	wire apb_write;
	wire conv_on;
	wire serial_on;
	wire serial_master;
	wire serial_slave;
	integer i;
	integer j;

	// merge write data into a 24-bit register under the apb byte strobes; the top byte has no storage
	function [`BPB_PORT_BITS-1:0] bpb_merge;
		input [`BPB_PORT_BITS-1:0] old_value;
		input [31:0] new_value;
		input [3:0] strobe;
		integer k;
		begin
			bpb_merge = old_value;
			for (k = 0; k < `BPB_PORT_BITS / 8; k = k + 1)
			begin
				if (strobe[k])
				begin
					bpb_merge[k*8 +: 8] = new_value[k*8 +: 8];
				end
			end
		end
	endfunction

	// widen a 24-bit field to a bus word with zero upper bits
	function [31:0] bpb_word;
		input [`BPB_PORT_BITS-1:0] value;
		begin
			bpb_word = {8'h00, value};
		end
	endfunction

	// pins pass four flops before anything looks at them
	bpb_pin_sync u_pin_sync
	(
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.pin_raw_in(pin_in),
		.pin_level_out(pin_level)
	);

	// zero wait states: data is prepared in setup, so the access phase always completes
	assign pready_out = psel_in & penable_in;
	assign apb_setup = psel_in & ~penable_in;
	assign apb_write = psel_in & penable_in & pwrite_in & ~next_slverr;

	assign conv_on = func_select[`BPB_FUNC_CONV];
	assign serial_on = func_select[`BPB_FUNC_SERIAL];
	assign serial_master = serial_on & func_select[`BPB_FUNC_MASTER];
	assign serial_slave = serial_on & ~func_select[`BPB_FUNC_MASTER];

	// terminal function decode; converter beats buzzer on p03 and slave serial beats divided_clock_out on p23
	always @*
	begin
		hw_owned = {`BPB_PORT_BITS{1'b0}};
		hw_drive = {`BPB_PORT_BITS{1'b0}};
		hw_value = {`BPB_PORT_BITS{1'b0}};
		thresh_inert = {`BPB_PORT_BITS{1'b0}};
		// converter terminals p00-p03, direction fixed by hardware
		if (conv_on)
		begin
			hw_owned[`BPB_P03:`BPB_P00] = 4'hf;
			thresh_inert[`BPB_P03:`BPB_P00] = 4'hf;
			hw_drive[`BPB_P03:`BPB_P01] = 3'h7;
			hw_value[`BPB_P01] = converter_reference_in;
			hw_value[`BPB_P02] = converter_sensor_in;
			hw_value[`BPB_P03] = converter_osc_out_in;
		end
		else if (special_enable[`BPB_SPC_BUZZ])
		begin
			hw_owned[`BPB_P03] = 1'b1;
			thresh_inert[`BPB_P03] = 1'b1;
			hw_drive[`BPB_P03] = 1'b1;
			hw_value[`BPB_P03] = buzzer_out_in;
		end
		// stopwatch direct inputs stay under software threshold control
		if (func_select[`BPB_FUNC_WATCH])
		begin
			hw_owned[`BPB_P11:`BPB_P10] = 2'h3;
		end
		// event counter inputs likewise
		if (func_select[`BPB_FUNC_EVENT])
		begin
			hw_owned[`BPB_P12] = 1'b1;
			hw_owned[`BPB_P43:`BPB_P41] = 3'h7;
		end
		// timer clock outputs
		if (special_enable[`BPB_SPC_TIMER_CLOCK_OUT_A])
		begin
			hw_owned[`BPB_P13] = 1'b1;
			thresh_inert[`BPB_P13] = 1'b1;
			hw_drive[`BPB_P13] = 1'b1;
			hw_value[`BPB_P13] = timer_clock_out_a_in;
		end
		if (special_enable[`BPB_SPC_TIMER_CLOCK_OUT_B])
		begin
			hw_owned[`BPB_P31] = 1'b1;
			thresh_inert[`BPB_P31] = 1'b1;
			hw_drive[`BPB_P31] = 1'b1;
			hw_value[`BPB_P31] = timer_clock_out_b_in;
		end
		if (special_enable[`BPB_SPC_TIMER_CLOCK_OUT_C])
		begin
			hw_owned[`BPB_P32] = 1'b1;
			thresh_inert[`BPB_P32] = 1'b1;
			hw_drive[`BPB_P32] = 1'b1;
			hw_value[`BPB_P32] = timer_clock_out_c_in;
		end
		if (special_enable[`BPB_SPC_TIMER_CLOCK_OUT_D])
		begin
			hw_owned[`BPB_P33] = 1'b1;
			thresh_inert[`BPB_P33] = 1'b1;
			hw_drive[`BPB_P33] = 1'b1;
			hw_value[`BPB_P33] = timer_clock_out_d_in;
		end
		// serial terminals p20-p23; sin and slave clock are peripheral inputs
		if (serial_on)
		begin
			hw_owned[`BPB_P22:`BPB_P20] = 3'h7;
			thresh_inert[`BPB_P21] = 1'b1;
			hw_drive[`BPB_P21] = 1'b1;
			hw_value[`BPB_P21] = serial_data_out_pin_in;
			if (serial_master)
			begin
				thresh_inert[`BPB_P20] = 1'b1;
				hw_drive[`BPB_P20] = 1'b1;
				hw_value[`BPB_P20] = serial_clock_master_in;
			end
		end
		if (serial_slave)
		begin
			hw_owned[`BPB_P23] = 1'b1;
			thresh_inert[`BPB_P23] = 1'b1;
			hw_drive[`BPB_P23] = 1'b1;
			hw_value[`BPB_P23] = serial_ready_out_in;
		end
		else if (special_enable[`BPB_SPC_DIVIDED_CLOCK_OUT])
		begin
			hw_owned[`BPB_P23] = 1'b1;
			thresh_inert[`BPB_P23] = 1'b1;
			hw_drive[`BPB_P23] = 1'b1;
			hw_value[`BPB_P23] = divided_clock_out_in;
		end
	end

	// pad controls per bit; the open-drain stage can only pull high, so it lets go on a low
	always @*
	begin
		want_drive = {`BPB_PORT_BITS{1'b0}};
		want_value = {`BPB_PORT_BITS{1'b0}};
		next_oe = {`BPB_PORT_BITS{1'b0}};
		next_pull = {`BPB_PORT_BITS{1'b0}};
		next_schmitt = {`BPB_PORT_BITS{1'b0}};
		for (i = 0; i < `BPB_PORT_BITS; i = i + 1)
		begin
			if (hw_owned[i])
			begin
				want_drive[i] = hw_drive[i];
				want_value[i] = hw_value[i];
			end
			else
			begin
				want_drive[i] = port_direction_bit[i];
				want_value[i] = port_data[i];
			end
			next_oe[i] = want_drive[i] & (want_value[i] | ~OPEN_DRAIN_MASK[i]);
			// pull-down only on fitted pads and only while not in output mode
			if (thresh_inert[i])
			begin
				next_pull[i] = PULLDOWN_FITTED[i] & ~want_drive[i];
			end
			else
			begin
				next_pull[i] = PULLDOWN_FITTED[i] & pulldown_enable_bit[i] & ~want_drive[i];
			end
			// an inert select leaves the pad on the schmitt default
			next_schmitt[i] = thresh_inert[i] | input_threshold_select[i];
		end
	end

	// port read: stored data for software outputs, synchronised pin otherwise
	always @*
	begin
		for (j = 0; j < `BPB_PORT_BITS; j = j + 1)
		begin
			if (~hw_owned[j] & port_direction_bit[j])
			begin
				read_port[j] = port_data[j];
			end
			else
			begin
				read_port[j] = pin_level[j];
			end
		end
	end

	// read mux and unmapped detection, decoded during setup
	always @*
	begin
		next_rdata = 32'h00000000;
		next_slverr = 1'b0;
		if (paddr_in == `BPB_OFS_DATA)
		begin
			next_rdata = bpb_word(read_port);
		end
		else if (paddr_in == `BPB_OFS_DIR)
		begin
			next_rdata = bpb_word(port_direction_bit);
		end
		else if (paddr_in == `BPB_OFS_PULL)
		begin
			next_rdata = bpb_word(pulldown_enable_bit);
		end
		else if (paddr_in == `BPB_OFS_THRESH)
		begin
			next_rdata = bpb_word(input_threshold_select);
		end
		else if (paddr_in == `BPB_OFS_FUNC)
		begin
			next_rdata = {27'h0, func_select};
		end
		else if (paddr_in == `BPB_OFS_SPECIAL)
		begin
			next_rdata = {26'h0, special_enable};
		end
		else if (paddr_in == `BPB_OFS_PINS)
		begin
			next_rdata = bpb_word(pin_level);
		end
		else
		begin
			next_slverr = 1'b1;
		end
	end

	// apb read data and error are captured in setup and held through the access phase
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			prdata_out <= 32'h00000000;
			pslverr_out <= 1'b0;
		end
		else if (apb_setup)
		begin
			prdata_out <= pwrite_in ? 32'h00000000 : next_rdata;
			pslverr_out <= next_slverr;
		end
	end

	// register writes land at the access edge; software must idle users first
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			port_data <= `BPB_RST_DATA;
			port_direction_bit <= `BPB_RST_DIR;
			pulldown_enable_bit <= `BPB_RST_PULL;
			input_threshold_select <= `BPB_RST_THRESH;
			func_select <= `BPB_RST_FUNC;
			special_enable <= `BPB_RST_SPECIAL;
		end
		else if (apb_write)
		begin
			if (paddr_in == `BPB_OFS_DATA)
			begin
				port_data <= bpb_merge(port_data, pwdata_in, pstrb_in);
			end
			else if (paddr_in == `BPB_OFS_DIR)
			begin
				port_direction_bit <= bpb_merge(port_direction_bit, pwdata_in, pstrb_in);
			end
			else if (paddr_in == `BPB_OFS_PULL)
			begin
				pulldown_enable_bit <= bpb_merge(pulldown_enable_bit, pwdata_in, pstrb_in);
			end
			else if (paddr_in == `BPB_OFS_THRESH)
			begin
				input_threshold_select <= bpb_merge(input_threshold_select, pwdata_in, pstrb_in);
			end
			else if (paddr_in == `BPB_OFS_FUNC)
			begin
				if (pstrb_in[0])
				begin
					func_select <= pwdata_in[`BPB_FUNC_BITS-1:0];
				end
			end
			else if (paddr_in == `BPB_OFS_SPECIAL)
			begin
				if (pstrb_in[0])
				begin
					special_enable <= pwdata_in[`BPB_SPC_BITS-1:0];
				end
			end
		end
	end

	// pad drive and peripheral inputs are registered so the pins see clean edges
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			pin_out <= {`BPB_PORT_BITS{1'b0}};
			pin_oe_out <= {`BPB_PORT_BITS{1'b0}};
			pulldown_on_out <= PULLDOWN_FITTED;
			schmitt_on_out <= {`BPB_PORT_BITS{1'b1}};
			converter_osc_in_out <= 1'b0;
			serial_clock_slave_out <= 1'b0;
			serial_data_in_pin_out <= 1'b0;
			watch_run_stop_out <= 1'b0;
			watch_lap_out <= 1'b0;
			event_count_in_a_out <= 1'b0;
			event_count_in_b_out <= 1'b0;
			event_count_in_c_out <= 1'b0;
			event_count_in_d_out <= 1'b0;
		end
		else
		begin
			pin_out <= want_value;
			pin_oe_out <= next_oe;
			pulldown_on_out <= next_pull;
			schmitt_on_out <= next_schmitt;
			converter_osc_in_out <= conv_on & pin_level[`BPB_P00];
			serial_clock_slave_out <= serial_slave & pin_level[`BPB_P20];
			serial_data_in_pin_out <= serial_on & pin_level[`BPB_P22];
			watch_run_stop_out <= func_select[`BPB_FUNC_WATCH] & pin_level[`BPB_P10];
			watch_lap_out <= func_select[`BPB_FUNC_WATCH] & pin_level[`BPB_P11];
			event_count_in_a_out <= func_select[`BPB_FUNC_EVENT] & pin_level[`BPB_P12];
			event_count_in_b_out <= func_select[`BPB_FUNC_EVENT] & pin_level[`BPB_P41];
			event_count_in_c_out <= func_select[`BPB_FUNC_EVENT] & pin_level[`BPB_P42];
			event_count_in_d_out <= func_select[`BPB_FUNC_EVENT] & pin_level[`BPB_P43];
		end
	end

endmodule // bpb_port_bank

// >>> tb/bpb_pad_model.sv
// pad model: keys and chips on the port pins, resolved against the bank's drivers
`timescale 1ns/1ps
`include "bpb_defs.vh"

module bpb_pad_model
(
	input wire clk_sys_in,
	input wire [`BPB_PORT_BITS-1:0] pin_out_in,
	input wire [`BPB_PORT_BITS-1:0] pin_oe_in,
	input wire [`BPB_PORT_BITS-1:0] pulldown_on_in,
	input wire [`BPB_PORT_BITS-1:0] key_en_in,
	input wire [`BPB_PORT_BITS-1:0] key_val_in,
	output logic [`BPB_PORT_BITS-1:0] pad_out
);
	logic flt = 1'b0;
	integer i;

	// floating pads wander every cycle so a stale level never reads as valid
	always @(posedge clk_sys_in)
	begin
		flt <= ~flt;
	end

	// bank driver wins, then an external key, then the pull-down, else the pad floats
	always @*
	begin
		for (i = 0; i < `BPB_PORT_BITS; i = i + 1)
		begin
			if (pin_oe_in[i])
				pad_out[i] = pin_out_in[i];
			else if (key_en_in[i])
				pad_out[i] = key_val_in[i];
			else if (pulldown_on_in[i])
				pad_out[i] = 1'b0;
			else
				pad_out[i] = flt;
		end
	end
endmodule // bpb_pad_model

// >>> tb/bpb_port_bank_chk.sv
// assertion checker for the port bank, bound to its ports
`timescale 1ns/1ps
`include "bpb_defs.vh"

module bpb_port_bank_chk
#(
	parameter [`BPB_PORT_BITS-1:0] OPEN_DRAIN_MASK = 24'h000000,
	parameter [`BPB_PORT_BITS-1:0] PULLDOWN_FITTED = 24'hffffff
)
(
	input wire clk_sys_in,
	input wire rst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [`BPB_ADDR_BITS-1:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	input wire [31:0] prdata_out,
	input wire pslverr_out,
	input wire [`BPB_PORT_BITS-1:0] pin_out,
	input wire [`BPB_PORT_BITS-1:0] pin_oe_out,
	input wire [`BPB_PORT_BITS-1:0] pulldown_on_out,
	input wire [`BPB_PORT_BITS-1:0] schmitt_on_out,
	input wire watch_run_stop_out,
	input wire watch_lap_out
);
	logic [`BPB_PORT_BITS-1:0] dir_sh;
	logic [`BPB_FUNC_BITS-1:0] func_sh;
	logic [`BPB_SPC_BITS-1:0] spc_sh;
	wire wr_go = psel_in && penable_in && pwrite_in;
	integer b;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	// shadow of the control words, taken at the access edge like the bank
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			dir_sh <= `BPB_RST_DIR;
			func_sh <= `BPB_RST_FUNC;
			spc_sh <= `BPB_RST_SPECIAL;
		end
		else if (wr_go)
		begin
			for (b = 0; b < 3; b = b + 1)
				if (paddr_in == `BPB_OFS_DIR && pstrb_in[b])
					dir_sh[b*8 +: 8] <= pwdata_in[b*8 +: 8];
			if (paddr_in == `BPB_OFS_FUNC && pstrb_in[0])
				func_sh <= pwdata_in[`BPB_FUNC_BITS-1:0];
			if (paddr_in == `BPB_OFS_SPECIAL && pstrb_in[0])
				spc_sh <= pwdata_in[`BPB_SPC_BITS-1:0];
		end
	end

	a_reset_inputs: assert property ($fell(rst_in) |-> pin_oe_out == 24'h000000 && !watch_run_stop_out)
		else $error("pads driven or peripheral input live after reset");
	a_reset_levels: assert property ($fell(rst_in) |-> schmitt_on_out == 24'hffffff && pulldown_on_out == PULLDOWN_FITTED)
		else $error("threshold or pull-down not at reset level");
	a_pull_input_only: assert property (((pulldown_on_out & pin_oe_out) | (pulldown_on_out & ~PULLDOWN_FITTED)) == 24'h000000)
		else $error("pull-down on a driven or unfitted pad");
	a_open_drain_high: assert property ((pin_oe_out & ~pin_out & OPEN_DRAIN_MASK) == 24'h000000)
		else $error("open-drain pad driven low");
	// pads follow a direction write two edges later while no shared function is active
	a_dir_drives: assert property (wr_go && paddr_in == `BPB_OFS_DIR && pstrb_in == 4'hf && func_sh == 5'h00 && spc_sh == 6'h00 |-> ##2 ((pin_oe_out ^ dir_sh) & ~OPEN_DRAIN_MASK) == 24'h000000)
		else $error("drive enable does not follow direction");
	a_special_drives: assert property (spc_sh[`BPB_SPC_TIMER_CLOCK_OUT_A] [*3] |-> pin_oe_out[`BPB_P13] && schmitt_on_out[`BPB_P13])
		else $error("special output pad not driven");
	a_watch_forces_in: assert property (func_sh[`BPB_FUNC_WATCH] [*3] |-> pin_oe_out[`BPB_P11:`BPB_P10] == 2'b00)
		else $error("stopwatch pads driven");
	a_watch_idle: assert property ((!func_sh[`BPB_FUNC_WATCH]) [*3] |-> !watch_run_stop_out && !watch_lap_out)
		else $error("stopwatch input live while unselected");
	a_dir_readback: assert property (psel_in && !penable_in && !pwrite_in && paddr_in == `BPB_OFS_DIR |=> prdata_out == {8'h00, dir_sh} && !pslverr_out)
		else $error("direction readback wrong");

	c_special: cover property (spc_sh[`BPB_SPC_TIMER_CLOCK_OUT_A] && pin_oe_out[`BPB_P13]);
	c_watch: cover property (watch_run_stop_out && watch_lap_out);
	c_dir_write: cover property (wr_go && paddr_in == `BPB_OFS_DIR);
endmodule // bpb_port_bank_chk

bind bpb_port_bank bpb_port_bank_chk #(.OPEN_DRAIN_MASK(OPEN_DRAIN_MASK), .PULLDOWN_FITTED(PULLDOWN_FITTED)) u_chk
(
	.clk_sys_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
	.pslverr_out, .pin_out, .pin_oe_out, .pulldown_on_out, .schmitt_on_out, .watch_run_stop_out, .watch_lap_out
);

// >>> tb/tb_bpb_port_bank.sv
// self-checking bench for the port bank: apb register tasks and pin scenarios
`timescale 1ns/1ps
`include "bpb_defs.vh"

module tb_bpb_port_bank;
	localparam [23:0] OD = 24'h00000f;
	localparam [23:0] FIT = 24'hfffff0;
	localparam [39:0] RA = {8'h14, 8'h10, 8'h0c, 8'h08, 8'h04};
	localparam [159:0] RV = {32'h0, 32'h0, 32'h00ffffff, 32'h00ffffff, 32'h0};
	localparam [29:0] SP = {5'd15, 5'd14, 5'd13, 5'd11, 5'd7, 5'd3};
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [23:0] key_en = 24'h0;
	logic [23:0] key_val = 24'h0;
	logic [5:0] spc_lvl = 6'h00;
	logic [5:0] per_lvl = 6'h00;
	wire pready, pslverr;
	wire [31:0] prdata;
	wire [23:0] pin_in, pin_out, pin_oe, pull_on, smt_on;
	wire [8:0] per_o;
	integer mismatches = 0;
	integer check_count = 0;
	integer n, k;
	logic [31:0] rd;
	logic err;

	// free-running system clock, 40 ns period
	always #20 clk_sys_in = ~clk_sys_in;

	bpb_port_bank #(.OPEN_DRAIN_MASK(OD), .PULLDOWN_FITTED(FIT)) dut
	(
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready), .prdata_out(prdata),
		.pslverr_out(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe), .pulldown_on_out(pull_on),
		.schmitt_on_out(smt_on), .buzzer_out_in(spc_lvl[0]), .timer_clock_out_a_in(spc_lvl[1]),
		.divided_clock_out_in(spc_lvl[2]), .timer_clock_out_b_in(spc_lvl[3]), .timer_clock_out_c_in(spc_lvl[4]),
		.timer_clock_out_d_in(spc_lvl[5]), .converter_reference_in(per_lvl[0]), .converter_sensor_in(per_lvl[1]),
		.converter_osc_out_in(per_lvl[2]), .serial_clock_master_in(per_lvl[3]), .serial_data_out_pin_in(per_lvl[4]),
		.serial_ready_out_in(per_lvl[5]), .converter_osc_in_out(per_o[0]), .serial_clock_slave_out(per_o[1]),
		.serial_data_in_pin_out(per_o[2]), .watch_run_stop_out(per_o[3]), .watch_lap_out(per_o[4]),
		.event_count_in_a_out(per_o[5]), .event_count_in_b_out(per_o[6]), .event_count_in_c_out(per_o[7]),
		.event_count_in_d_out(per_o[8])
	);

	bpb_pad_model pads
	(
		.clk_sys_in(clk_sys_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe), .pulldown_on_in(pull_on),
		.key_en_in(key_en), .key_val_in(key_val), .pad_out(pin_in)
	);

	task stop_test;
		begin
			$display("comparisons %0d, mismatches %0d", check_count, mismatches);
			if (mismatches == 0 && check_count > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		begin
			check_count = check_count + 1;
			if (got !== exp)
			begin
				mismatches = mismatches + 1;
				$display("[FAIL] %s expected %h seen %h", what, exp, got);
			end
		end
	endtask

	// one apb transfer; holds the request until pready is sampled high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		begin
			@(posedge clk_sys_in);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			pstrb <= s;
			@(posedge clk_sys_in);
			penable <= 1'b1;
			n = 0;
			@(posedge clk_sys_in);
			while (pready !== 1'b1 && n < 16)
			begin
				n = n + 1;
				@(posedge clk_sys_in);
			end
			if (n >= 16)
			begin
				mismatches = mismatches + 1;
				$display("[FAIL] pready expected 1 seen timeout");
				stop_test;
			end
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 4'hf);
	endtask

	task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		begin
			xfer(1'b0, a, 32'h0, 4'h0);
			chk(what, exp, rd);
		end
	endtask

	// pin changes need the synchroniser plus one stage before they show
	task settle;
		repeat (8) @(posedge clk_sys_in);
	endtask

	initial
	begin
		repeat (3) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		for (k = 0; k < 5; k = k + 1)
			rchk("reset reg", RA[k*8 +: 8], RV[k*32 +: 32]);
		chk("pull pads", {8'h0, FIT}, {8'h0, pull_on});
		chk("schmitt", 32'h00ffffff, {8'h0, smt_on});
		chk("drive enable", 32'h0, {8'h0, pin_oe});
		$display("test reset done");
		// partial strobes: only the middle byte of the second write lands
		for (k = 0; k < 3; k = k + 1)
		begin
			xfer(1'b1, RA[k*8 +: 8], 32'hff123456, 4'hf);
			xfer(1'b1, RA[k*8 +: 8], 32'h00ffffff, 4'b0010);
			rchk("rw reg", RA[k*8 +: 8], 32'h0012ff56);
		end
		$display("test storage done");
		wr(`BPB_OFS_DIR, 32'h000000ff);
		wr(`BPB_OFS_DATA, 32'h000000a5);
		wr(`BPB_OFS_PULL, 32'h00ffffff);
		wr(`BPB_OFS_THRESH, 32'h0000f0f0);
		key_en <= 24'hffff00;
		key_val <= 24'h5a3c00;
		settle;
		rchk("data mixed", `BPB_OFS_DATA, 32'h005a3ca5);
		chk("drive enable", 32'h000000f5, {8'h0, pin_oe});
		chk("pad drive", 32'h000000a0, {8'h0, pin_out & 24'h0000f0});
		chk("pull pads", 32'h00ffff00, {8'h0, pull_on});
		chk("schmitt", 32'h0000f0f0, {8'h0, smt_on});
		xfer(1'b0, `BPB_OFS_PINS, 32'h0, 4'h0);
		chk("pins", 32'h005a3ca5, rd & 32'h00fffff5);
		wr(`BPB_OFS_DIR, 32'h0);
		settle;
		xfer(1'b0, `BPB_OFS_DATA, 32'h0, 4'h0);
		chk("data input", 32'h005a3c00, rd & 32'h00fffff0);
		chk("pull pads", {8'h0, FIT}, {8'h0, pull_on});
		$display("test port modes done");
		xfer(1'b0, 8'h1c, 32'h0, 4'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		xfer(1'b1, `BPB_OFS_PINS, 32'hffffffff, 4'hf);
		rchk("dir kept", `BPB_OFS_DIR, 32'h0);
		$display("test refusals done");
		key_en <= 24'h0;
		wr(`BPB_OFS_THRESH, 32'h0);
		for (k = 0; k < 6; k = k + 1)
		begin
			wr(`BPB_OFS_SPECIAL, 32'h1 << k);
			spc_lvl <= 6'h3f;
			settle;
			chk("special oe", 32'h1, {31'h0, pin_oe[SP[k*5 +: 5]]});
			chk("special high", 32'h1, {31'h0, pin_out[SP[k*5 +: 5]]});
			chk("special schmitt", 32'h1, {31'h0, smt_on[SP[k*5 +: 5]]});
			spc_lvl <= 6'h00;
			settle;
			chk("special low", 32'h0, {31'h0, pin_out[SP[k*5 +: 5]]});
		end
		wr(`BPB_OFS_SPECIAL, 32'h0);
		rchk("dir stored", `BPB_OFS_DIR, 32'h0);
		$display("test special outputs done");
		wr(`BPB_OFS_DIR, 32'h00ffffff);
		wr(`BPB_OFS_FUNC, 32'h18);
		key_en <= 24'h0e0070;
		key_val <= 24'h0e0070;
		settle;
		chk("inputs undriven", 32'h0, {8'h0, pin_oe & 24'h0e0070});
		chk("timer inputs", 32'h3f, {26'h0, per_o[8:3]});
		chk("input schmitt", 32'h0, {8'h0, smt_on & 24'h0e0070});
		// the user circuit is released before the terminal changes function
		wr(`BPB_OFS_FUNC, 32'h0);
		settle;
		chk("timer idle", 32'h0, {26'h0, per_o[8:3]});
		wr(`BPB_OFS_FUNC, 32'h1);
		key_en <= 24'h000001;
		key_val <= 24'h000001;
		settle;
		chk("converter in", 32'h1, {31'h0, per_o[0]});
		chk("converter schmitt", 32'hf, {28'h0, smt_on[3:0]});
		wr(`BPB_OFS_FUNC, 32'h0);
		wr(`BPB_OFS_FUNC, 32'h2);
		key_en <= 24'h000500;
		key_val <= 24'h000500;
		per_lvl <= 6'h10;
		settle;
		chk("serial in", 32'h3, {30'h0, per_o[2:1]});
		chk("serial out", 32'h3, {30'h0, pin_oe[9], pin_out[9]});
		$display("test shared functions done");
		stop_test;
	end
endmodule // tb_bpb_port_bank
